// ### logic/pmic_defines.vh
/*
 power mode and interrupt control: register offsets, field positions,
 reset values, vector table constants and timing counts.
 assumes inclusion by bare name from the design files.
*/
`ifndef PMIC_DEFINES_VH
`define PMIC_DEFINES_VH

// register byte addresses (word aligned on the bus)
`define PMIC_ADDR_STATUS 8'h00
`define PMIC_ADDR_IRQ_EN 8'h04
`define PMIC_ADDR_IRQ_FLAG 8'h08
`define PMIC_ADDR_MOD_EN 8'h0C
`define PMIC_ADDR_MODE 8'h10
`define PMIC_ADDR_VECTOR 8'h14
`define PMIC_ADDR_VTAB 8'h40

// status word field positions
`define PMIC_SR_CARRY 0
`define PMIC_SR_ZERO 1
`define PMIC_SR_NEG 2
`define PMIC_SR_GIE 3
`define PMIC_SR_CPU_HALT 4
`define PMIC_SR_OSC_STOP 5
`define PMIC_SR_SCG_LO 6
`define PMIC_SR_SCG_HI 7
`define PMIC_SR_USED_MASK 16'h01FF
`define PMIC_SR_RESET 16'h0000

// interrupt source bit positions in enable and flag registers
`define PMIC_SRC_NMI_PIN 0
`define PMIC_SRC_OSC_FAULT 1
`define PMIC_SRC_PIN0 2
`define PMIC_SRC_PIN1 3
`define PMIC_SRC_WDOG 4
`define PMIC_SRC_CONV 5
`define PMIC_SRC_TPORT 6
`define PMIC_SRC_BTIMER 7
`define PMIC_SRC_PINS27 8
`define PMIC_NSRC 9

// vector table: top 32 bytes of memory, priority n at 0FFE0h + 2n
`define PMIC_VTAB_BASE 16'hFFE0
`define PMIC_PRIO_RESET 4'hF
`define PMIC_PRIO_NMI 4'hE
`define PMIC_PRIO_PIN0 4'hD
`define PMIC_PRIO_PIN1 4'hC
`define PMIC_PRIO_WDOG 4'hA
`define PMIC_PRIO_CONV 4'h5
`define PMIC_PRIO_TPORT 4'h4
`define PMIC_PRIO_BTIMER 4'h1
`define PMIC_PRIO_PINS27 4'h0

// operating mode codes
`define PMIC_MODE_ACTIVE 3'h0
`define PMIC_MODE_LOW_POWER_MODE_0 3'h1
`define PMIC_MODE_LOW_POWER_MODE_1 3'h2
`define PMIC_MODE_LOW_POWER_MODE_2 3'h3
`define PMIC_MODE_LOW_POWER_MODE_3 3'h4
`define PMIC_MODE_LOW_POWER_MODE_4 3'h5

// watchdog: key in high byte of a write, timeout in microseconds
`define PMIC_WDOG_KEY 8'h5A
`define PMIC_WDOG_TIME_US 1000
`define PMIC_CLK_MHZ 100
`define PMIC_WDOG_CYCLES (`PMIC_WDOG_TIME_US * `PMIC_CLK_MHZ)

`endif

// ### logic/pmic_top.v
/*
 power mode and interrupt control: status word, operating modes and clock
 gating, flag/enable registers, priority arbitration and vector fetch.
 assumes a classic wishbone master on mclk and source event pulses that
 are already synchronous to mclk, except the nmi pin which is synchronised.
*/
`timescale 1ns/1ps
`include "pmic_defines.vh"
module pmic_top #(
    parameter NMOD = 8,
    parameter WDOG_CYCLES = `PMIC_WDOG_CYCLES
) (
    input wire mclk,
    input wire nrst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    input wire nmi_pin,
    input wire osc_fault_evt,
    input wire pin0_evt,
    input wire pin1_evt,
    input wire conv_evt,
    input wire tport_req,
    input wire btimer_evt,
    input wire pins27_evt,
    input wire irq_ack,
    input wire return_from_interrupt,
    output reg cpu_run,
    output reg mclk_en,
    output reg fll_en,
    output reg dco_dc_en,
    output reg aclk_en,
    output reg [NMOD-1:0] mod_run,
    output reg irq_req,
    output reg [15:0] irq_vector,
    output reg reset_req
);

reg [15:0] sr_q;
reg [15:0] sr_saved_q;
reg [`PMIC_NSRC-1:0] ien_q;
reg [`PMIC_NSRC-1:0] ifg_q;
reg [NMOD-1:0] men_q;
reg [31:0] wdog_cnt_q;
reg wdog_rst_q;
reg nmi_s1_q;
reg nmi_s2_q;
reg nmi_s3_q;
reg [3:0] sel_prio_q;
reg in_isr_q;
reg vt_pend_q;

wire wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
wire wb_wr = wb_req & wb_we_i;
wire wb_rd = wb_req & ~wb_we_i;
wire vt_wr = wb_wr & (wb_adr_i >= `PMIC_ADDR_VTAB) & (wb_adr_i < 8'h80);
wire [3:0] vt_waddr = wb_adr_i[5:2];
wire [15:0] vt_rdata;

// mode code from the four control bits of the status word
function [2:0] mode_of;
    input [15:0] sr;
    begin
        if (!sr[`PMIC_SR_CPU_HALT]) begin
            mode_of = `PMIC_MODE_ACTIVE;
        end else if (sr[`PMIC_SR_OSC_STOP]) begin
            mode_of = `PMIC_MODE_LOW_POWER_MODE_4;
        end else if (sr[`PMIC_SR_SCG_HI] & sr[`PMIC_SR_SCG_LO]) begin
            mode_of = `PMIC_MODE_LOW_POWER_MODE_3;
        end else if (sr[`PMIC_SR_SCG_HI]) begin
            mode_of = `PMIC_MODE_LOW_POWER_MODE_2;
        end else if (sr[`PMIC_SR_SCG_LO]) begin
            mode_of = `PMIC_MODE_LOW_POWER_MODE_1;
        end else begin
            mode_of = `PMIC_MODE_LOW_POWER_MODE_0;
        end
    end
endfunction

// byte-lane merge of a 16-bit register write
function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0] sel;
    begin
        merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
    end
endfunction

// nmi pin synchronised, edge detected off second stage
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        nmi_s1_q <= 1'b0;
        nmi_s2_q <= 1'b0;
        nmi_s3_q <= 1'b0;
    end else begin
        nmi_s1_q <= nmi_pin;
        nmi_s2_q <= nmi_s1_q;
        nmi_s3_q <= nmi_s2_q;
    end
end

wire nmi_evt = nmi_s2_q & ~nmi_s3_q;

wire wdog_wr = wb_wr & (wb_adr_i == `PMIC_ADDR_MODE) & wb_sel_i[1];
wire wdog_bad = wdog_wr & (wb_dat_i[15:8] != `PMIC_WDOG_KEY);
wire wdog_ovf = (wdog_cnt_q == WDOG_CYCLES - 1);
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        wdog_cnt_q <= 32'h0;
        wdog_rst_q <= 1'b0;
    end else begin
        wdog_rst_q <= wdog_ovf | wdog_bad;
        if (wdog_wr | wdog_ovf) begin
            wdog_cnt_q <= 32'h0;
        end else begin
            wdog_cnt_q <= wdog_cnt_q + 32'h1;
        end
    end
end

// maskable gated by own and global enable
wire global_irq_enable = sr_q[`PMIC_SR_GIE];
wire [`PMIC_NSRC-1:0] acc;
assign acc[`PMIC_SRC_NMI_PIN] = ifg_q[`PMIC_SRC_NMI_PIN];
assign acc[`PMIC_SRC_OSC_FAULT] = ifg_q[`PMIC_SRC_OSC_FAULT] & ien_q[`PMIC_SRC_OSC_FAULT];
genvar gi;
generate
    for (gi = `PMIC_SRC_PIN0; gi < `PMIC_NSRC; gi = gi + 1) begin : g_mask
        // timer/port request is a level whose flags live outside
        assign acc[gi] = ((gi == `PMIC_SRC_TPORT) ? tport_req : ifg_q[gi]) & ien_q[gi] & global_irq_enable;
    end
endgenerate

// fixed priority chain, highest first; only assigned slots
reg [3:0] win_prio;
reg win_any;
always @* begin
    win_any = 1'b1;
    win_prio = `PMIC_PRIO_PINS27;
    if (acc[`PMIC_SRC_NMI_PIN] | acc[`PMIC_SRC_OSC_FAULT]) begin
        win_prio = `PMIC_PRIO_NMI;
    end else if (acc[`PMIC_SRC_PIN0]) begin
        win_prio = `PMIC_PRIO_PIN0;
    end else if (acc[`PMIC_SRC_PIN1]) begin
        win_prio = `PMIC_PRIO_PIN1;
    end else if (acc[`PMIC_SRC_WDOG]) begin
        win_prio = `PMIC_PRIO_WDOG;
    end else if (acc[`PMIC_SRC_CONV]) begin
        win_prio = `PMIC_PRIO_CONV;
    end else if (acc[`PMIC_SRC_TPORT]) begin
        win_prio = `PMIC_PRIO_TPORT;
    end else if (acc[`PMIC_SRC_BTIMER]) begin
        win_prio = `PMIC_PRIO_BTIMER;
    end else if (!acc[`PMIC_SRC_PINS27]) begin
        win_any = 1'b0;
    end
end

// vector table read; reset selects slot 15
// looked up one cycle early so the reset vector stands together with reset_req
wire [3:0] vt_raddr = (wdog_ovf | wdog_bad) ? `PMIC_PRIO_RESET : win_prio;

pmic_vtab_mem #(
    .DEPTH_LOG2(4),
    .WIDTH(16)
) u_vtab (
    .mclk(mclk),
    .wr_en(vt_wr),
    .wr_addr(vt_waddr),
    .wr_data(wb_dat_i[15:0]),
    .rd_addr(vt_raddr),
    .rd_data(vt_rdata)
);

// flag sources; set wins over software clear, timer/port flag is external
wire [15:0] ien_wr = merge16({7'h0, ien_q}, wb_dat_i, wb_sel_i);
wire [`PMIC_NSRC-1:0] set_v = {pins27_evt, btimer_evt, 1'b0, conv_evt, wdog_ovf | wdog_bad,
    pin1_evt, pin0_evt, osc_fault_evt, nmi_evt};
wire take = irq_req & irq_ack;

// status word, enables, flags, isr state
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        // oscillator-stop cleared so the oscillator starts
        sr_q <= `PMIC_SR_RESET;
        sr_saved_q <= `PMIC_SR_RESET;
        ien_q <= {`PMIC_NSRC{1'b0}};
        ifg_q <= {`PMIC_NSRC{1'b0}};
        men_q <= {NMOD{1'b0}};
        in_isr_q <= 1'b0;
        sel_prio_q <= 4'h0;
    end else begin
        // status word layout, upper bits reserved zero
        if (wb_wr & (wb_adr_i == `PMIC_ADDR_STATUS)) begin
            sr_q <= merge16(sr_q, wb_dat_i, wb_sel_i) & `PMIC_SR_USED_MASK;
        end else if (take) begin
            // save mode, wake to active, mask further maskables
            sr_saved_q <= sr_q;
            sr_q <= sr_q & ~16'h00F8;
        end else if (return_from_interrupt & in_isr_q) begin
            sr_q <= sr_saved_q;
        end
        if (take) begin
            in_isr_q <= 1'b1;
            sel_prio_q <= win_prio;
        end else if (return_from_interrupt) begin
            in_isr_q <= 1'b0;
        end
        if (wb_wr & (wb_adr_i == `PMIC_ADDR_IRQ_EN)) begin
            ien_q <= ien_wr[`PMIC_NSRC-1:0];
        end
        if (wb_wr & (wb_adr_i == `PMIC_ADDR_MOD_EN) & wb_sel_i[0]) begin
            men_q <= wb_dat_i[NMOD-1:0];
        end
        // write one to clear; event set in the same cycle wins
        ifg_q <= ((ifg_q & ~((wb_wr & (wb_adr_i == `PMIC_ADDR_IRQ_FLAG) & wb_sel_i[0])
            ? {1'b0, wb_dat_i[7:0]} : 9'h0)) | set_v) & 9'h1BF;
        if (wb_wr & (wb_adr_i == `PMIC_ADDR_IRQ_FLAG) & wb_sel_i[1] & wb_dat_i[8]) begin
            ifg_q[`PMIC_SRC_PINS27] <= pins27_evt;
        end
        // only the pin0 flag clears itself when serviced
        if (take & (win_prio == `PMIC_PRIO_PIN0)) begin
            ifg_q[`PMIC_SRC_PIN0] <= pin0_evt;
        end
    end
end

wire [2:0] mode = mode_of(sr_q);
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        cpu_run <= 1'b0;
        mclk_en <= 1'b0;
        fll_en <= 1'b0;
        dco_dc_en <= 1'b0;
        aclk_en <= 1'b0;
        mod_run <= {NMOD{1'b0}};
        irq_req <= 1'b0;
        irq_vector <= 16'h0;
        reset_req <= 1'b0;
        vt_pend_q <= 1'b0;
    end else begin
        cpu_run <= (mode == `PMIC_MODE_ACTIVE);
        mclk_en <= (mode == `PMIC_MODE_ACTIVE) | (mode == `PMIC_MODE_LOW_POWER_MODE_0) | (mode == `PMIC_MODE_LOW_POWER_MODE_1);
        fll_en <= (mode == `PMIC_MODE_ACTIVE) | (mode == `PMIC_MODE_LOW_POWER_MODE_0);
        dco_dc_en <= (mode != `PMIC_MODE_LOW_POWER_MODE_3) & (mode != `PMIC_MODE_LOW_POWER_MODE_4);
        aclk_en <= (mode != `PMIC_MODE_LOW_POWER_MODE_4);
        // module gating never blocks register access
        mod_run <= men_q;
        reset_req <= wdog_rst_q;
        // vector word and request both two cycles behind arbitration
        vt_pend_q <= win_any & ~in_isr_q & ~take;
        irq_req <= vt_pend_q & win_any & ~in_isr_q & ~take;
        irq_vector <= vt_rdata;
    end
end

// wishbone slave: one wait state, unmapped reads return zero
always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0;
    end else begin
        wb_ack_o <= wb_req;
        if (wb_rd) begin
            if (wb_adr_i == `PMIC_ADDR_STATUS) begin
                wb_dat_o <= {16'h0, sr_q};
            end else if (wb_adr_i == `PMIC_ADDR_IRQ_EN) begin
                wb_dat_o <= {23'h0, ien_q};
            end else if (wb_adr_i == `PMIC_ADDR_IRQ_FLAG) begin
                wb_dat_o <= {23'h0, ifg_q};
            end else if (wb_adr_i == `PMIC_ADDR_MOD_EN) begin
                wb_dat_o <= {{(32-NMOD){1'b0}}, men_q};
            end else if (wb_adr_i == `PMIC_ADDR_MODE) begin
                wb_dat_o <= {29'h0, mode};
            end else if (wb_adr_i == `PMIC_ADDR_VECTOR) begin
                wb_dat_o <= {11'h0, in_isr_q, sel_prio_q, irq_vector};
            end else begin
                wb_dat_o <= 32'h0;
            end
        end
    end
end

endmodule

// ### logic/pmic_vtab_mem.v
/*
 vector table memory: sixteen 16-bit entries, registered read data.
 assumes one clock; write and read ports are independent.
*/
`timescale 1ns/1ps
module pmic_vtab_mem #(
    parameter DEPTH_LOG2 = 4,
    parameter WIDTH = 16
) (
    input wire mclk,
    input wire wr_en,
    input wire [DEPTH_LOG2-1:0] wr_addr,
    input wire [WIDTH-1:0] wr_data,
    input wire [DEPTH_LOG2-1:0] rd_addr,
    output reg [WIDTH-1:0] rd_data
);

reg [WIDTH-1:0] mem [0:(1<<DEPTH_LOG2)-1];

// no reset on the array; software loads the table before enabling sources
always @(posedge mclk) begin
    if (wr_en) begin
        mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
end

endmodule

// ### tb/pmic_cpu_model.sv
/*
 cpu core model: takes requests after lag cycles, returns on done_isr.
 assumes a synchronous request level; lag 0 holds requests off.
*/
`timescale 1ns/1ps
module pmic_cpu_model (
    input wire mclk,
    input wire nrst,
    input wire irq_req,
    input wire [15:0] irq_vector,
    input wire [3:0] lag,
    input wire done_isr,
    output reg irq_ack,
    output reg return_from_interrupt,
    output reg [15:0] got_vec,
    output integer takes
);
    reg in_isr;
    reg [3:0] cnt;

    // vector loaded on take, return restores mode
    always @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            irq_ack <= 1'h0;
            return_from_interrupt <= 1'h0;
            got_vec <= 16'h0000;
            takes <= 0;
            in_isr <= 1'h0;
            cnt <= 4'h0;
        end else begin
            irq_ack <= 1'h0;
            return_from_interrupt <= 1'h0;
            cnt <= 4'h0;
            // a slow core lets the request wait
            if (irq_req && !in_isr && lag != 4'h0) begin
                cnt <= cnt + 4'h1;
                if (cnt >= lag) begin
                    irq_ack <= 1'h1;
                    in_isr <= 1'h1;
                    got_vec <= irq_vector;
                    takes <= takes + 1;
                end
            end
            if (in_isr && done_isr) begin
                return_from_interrupt <= 1'h1;
                in_isr <= 1'h0;
            end
        end
    end
endmodule

// ### tb/pmic_top_asserts.sv
/*
 checker for the power mode and interrupt block.
 assumes it is bound onto pmic_top and sees its ports only.
*/
`timescale 1ns/1ps
module pmic_top_asserts #(
    parameter NMOD = 8,
    parameter WDOG_CYCLES = 100000
) (
    input wire mclk,
    input wire nrst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    input wire nmi_pin,
    input wire osc_fault_evt,
    input wire pin0_evt,
    input wire pin1_evt,
    input wire conv_evt,
    input wire tport_req,
    input wire btimer_evt,
    input wire pins27_evt,
    input wire irq_ack,
    input wire return_from_interrupt,
    input wire cpu_run,
    input wire mclk_en,
    input wire fll_en,
    input wire dco_dc_en,
    input wire aclk_en,
    input wire [NMOD-1:0] mod_run,
    input wire irq_req,
    input wire [15:0] irq_vector,
    input wire reset_req
);
    // one clock domain, so one default clock and reset for all checks
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst);

    ack_once_a: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    ack_timely_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered in one cycle");
    aclk_off_a: assert property (!aclk_en |-> !mclk_en && !fll_en && !dco_dc_en && !cpu_run)
        else $error("crystal stopped with other clocks on");
    dco_off_a: assert property (!dco_dc_en |-> !mclk_en && !fll_en && !cpu_run)
        else $error("dc generator off with main clock on");
    mclk_off_a: assert property (!mclk_en |-> !fll_en && !cpu_run) else $error("loop on without main clock");
    take_wake_a: assert property (irq_ack |-> ##2 (cpu_run && mclk_en && fll_en && dco_dc_en && aclk_en))
        else $error("taken request did not wake");
    req_drop_a: assert property (irq_ack |-> ##2 !irq_req [*2]) else $error("request stayed after take");
    rst_pulse_a: assert property (reset_req |=> !reset_req) else $error("reset request not a pulse");

    // main scenarios reached
    take_c: cover property (irq_ack);
    deep_c: cover property (!aclk_en);
    wdog_c: cover property (reset_req);
endmodule

bind pmic_top pmic_top_asserts #(.NMOD(NMOD), .WDOG_CYCLES(WDOG_CYCLES)) chk_u (.*);

// ### tb/testbench.sv
/*
 self-checking bench for the power mode and interrupt block.
 assumes the cpu model answers requests; sources are driven here.
*/
`timescale 1ns/1ps
module testbench;
    localparam int WD = 3000;
    logic mclk = '0, nrst = '0, wb_cyc_i = '0, wb_stb_i = '0, wb_we_i = '0, nmi_pin = '0, tport_req = '0;
    logic osc_fault_evt = '0, pin0_evt = '0, pin1_evt = '0, conv_evt = '0, btimer_evt = '0, pins27_evt = '0;
    logic [7:0] wb_adr_i = '0, mod_run;
    logic [3:0] wb_sel_i = 4'h3, lag = '0;
    logic [31:0] wb_dat_i = '0, wb_dat_o;
    logic wb_ack_o, irq_ack, return_from_interrupt, cpu_run, mclk_en, fll_en, dco_dc_en, aclk_en, irq_req, reset_req, done_isr = '0;
    logic [15:0] irq_vector, got_vec, q;
    logic [15:0] srv [6] = '{16'h0000, 16'h0010, 16'h0050, 16'h0090, 16'h00D0, 16'h00F0};
    logic [4:0] ck [6] = '{5'h1F, 5'h0F, 5'h0B, 5'h03, 5'h01, 5'h00};
    integer takes, n;
    int err_total = 0, checks_done = 0;
    logic [15:0] rst_vec = '0;
    int rst_seen = 0;

    pmic_top #(.WDOG_CYCLES(WD)) dut_u (.*);
    pmic_cpu_model cpu_u (.*);

    // 100 MHz clock
    initial begin
        forever #5 mclk = ~mclk;
    end

    // count reset requests and keep the vector shown with them
    always @(posedge mclk) begin
        if (reset_req === 1'h1) begin
            rst_seen <= rst_seen + 1;
            rst_vec <= irq_vector;
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask

    // classic cycle; extra idle edge lets the write land before checks
    task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
        int k;
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, 16'h0000, d};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (wb_ack_o !== 1'h1 && k < 20);
        q = wb_dat_o[15:0];
        {wb_cyc_i, wb_stb_i} <= 2'h0;
        if (wb_ack_o !== 1'h1) begin
            err_total++;
            wrap_up();
        end
        @(posedge mclk);
    endtask

    task automatic fire(logic [5:0] m);
        @(posedge mclk);
        {osc_fault_evt, pin0_evt, pin1_evt, conv_evt, btimer_evt, pins27_evt} <= m;
        @(posedge mclk);
        {osc_fault_evt, pin0_evt, pin1_evt, conv_evt, btimer_evt, pins27_evt} <= 6'h00;
    endtask

    // wait for a take, check vector and woken status, then return
    task automatic serve(string nm, logic [15:0] v, logic [15:0] clr);
        int t;
        t = takes;
        for (int k = 0; k < 60 && takes == t; k++) @(posedge mclk);
        if (takes == t) err_total++;
        if (takes == t) wrap_up();
        chk(nm, v, got_vec);
        bus(0, 8'h00, 16'h0000);
        chk("isr status", 0, q & 16'h00F8);
        tport_req <= 1'h0;
        bus(1, 8'h08, clr);
        done_isr <= 1'h1;
        @(posedge mclk);
        done_isr <= 1'h0;
        repeat (4) @(posedge mclk);
    endtask

    initial begin
        repeat (6) @(posedge mclk);
        nrst <= 1'h1;
        bus(0, 8'h00, 0); chk("status", 0, q);
        bus(0, 8'hFC, 0); chk("unmapped", 0, q);
        for (int m = 0; m < 6; m++) begin
            bus(1, 8'h00, srv[m]);
            chk("clocks", ck[m], {cpu_run, mclk_en, fll_en, dco_dc_en, aclk_en});
            bus(0, 8'h10, 0); chk("mode", m, q);
        end
        bus(1, 8'h00, 16'hFF0F); bus(0, 8'h00, 0); chk("status", 16'h010F, q);
        bus(1, 8'h0C, 16'h00A5); chk("mod_run", 8'hA5, mod_run);
        bus(0, 8'h0C, 0); chk("mod enable", 16'h00A5, q);
        for (int i = 0; i < 16; i++) bus(1, 8'(8'h40 + 4 * i), 16'(16'hB000 + i));
        $display("registers and modes done");
        bus(1, 8'h04, 16'h01FF); bus(1, 8'h00, 16'h0008);
        fire(6'h1D);
        lag <= 4'h2;
        serve("pin0", 16'hB00D, 0);
        serve("pin1", 16'hB00C, 16'h0008);
        serve("conv", 16'hB005, 16'h0020);
        serve("pins27", 16'hB000, 16'h0100);
        $display("priority done");
        bus(1, 8'h00, 0); fire(6'h04); n = takes;
        repeat (20) @(posedge mclk);
        chk("gie masks", n, takes);
        bus(1, 8'h00, 16'h0008); serve("conv", 16'hB005, 16'h0020);
        bus(1, 8'h00, 0); bus(1, 8'h04, 16'h01FD); fire(6'h20); n = takes;
        repeat (20) @(posedge mclk);
        chk("osc masked", n, takes);
        bus(1, 8'h04, 16'h01FF); serve("osc", 16'hB00E, 16'h0002);
        bus(1, 8'h04, 0); nmi_pin <= 1'h1;
        serve("nmi", 16'hB00E, 16'h0001);
        nmi_pin <= 1'h0;
        bus(1, 8'h04, 16'h0040); bus(1, 8'h00, 16'h0008); tport_req <= 1'h1;
        serve("tport", 16'hB004, 0);
        bus(0, 8'h08, 0); chk("tport flag", 0, q & 16'h0040);
        bus(1, 8'h04, 16'h0080); bus(1, 8'h00, 16'h00D8); fire(6'h02);
        serve("btimer", 16'hB001, 16'h0080);
        bus(0, 8'h10, 0); chk("mode back", 4, q);
        $display("masking and wake done");
        bus(1, 8'h00, 0); bus(1, 8'h04, 0); bus(1, 8'h10, 16'h0000);
        repeat (20) @(posedge mclk);
        bus(0, 8'h08, 0); chk("bad key", 16'h0010, q & 16'h0010);
        chk("reset vec", 16'hB00F, rst_vec);
        chk("reset count", 1, rst_seen);
        bus(1, 8'h08, 16'h0010); bus(1, 8'h10, 16'h5A00);
        repeat (WD + 20) @(posedge mclk);
        bus(0, 8'h08, 0); chk("overflow", 16'h0010, q & 16'h0010);
        chk("reset count", 2, rst_seen);
        $display("watchdog done");
        wrap_up();
    end
endmodule
